/* File: logic/msas_pkg.sv */
// Package: constants, register map, channel order and timing for the monitor bus block
package msas_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CONV_INTERVAL_NS = 11600000; // Ordinary channel slot, 11.6 ms
  localparam int unsigned DIODE_SLOT_NS = 34800000; // Remote diode slot, 34.8 ms
  localparam int unsigned DIODE_AVG_COUNT = 16;
  localparam int unsigned CONV_CYC = CONV_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int unsigned DIODE_SLOT_CYC = DIODE_SLOT_NS / CLK_PERIOD_NS;
  localparam int unsigned DIODE_SUB_CYC = DIODE_SLOT_CYC / DIODE_AVG_COUNT;
  localparam int unsigned TIMER_W = 20;
  // ==========================================================
  // Slave address
  localparam logic [4:0] ADDR_UPPER = 5'h0b; // Fixed upper bits 01011
  localparam logic [1:0] ADDR_LOW_OPEN = 2'h2; // Strap left open
  localparam logic [1:0] ADDR_LOW_GND = 2'h0;
  localparam logic [1:0] ADDR_LOW_VCC = 2'h1;
  // ==========================================================
  // Register map
  localparam logic [7:0] VALUE_BASE = 8'h20; // Value registers at base + channel
  localparam logic [7:0] CONFIG_ADDR = 8'h40;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int unsigned CFG_START_BIT = 0;
  localparam logic [7:0] CODE_NOMINAL = 8'hc0; // Nominal supply gives three-quarter scale
  // ==========================================================
  // Channel order
  localparam int unsigned NUM_CHAN = 8;
  localparam logic [2:0] CHAN_FIRST = 3'h0; // Five external voltages at 0..4
  localparam logic [2:0] CHAN_VCC = 3'h5;
  localparam logic [2:0] CHAN_LOCAL_TEMP = 3'h6;
  localparam logic [2:0] CHAN_REMOTE_DIODE = 3'h7;
  // ==========================================================
  // Bus slave states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_RACK, ST_IGNORE
  } msas_state_type;
endpackage : msas_pkg

/* File: logic/msas_seq_if.sv */
// Interface: run control and value-register writes between bus slave and sequencer
`timescale 1ns/1ps
interface msas_seq_if;
  logic run;
  logic wr_en;
  logic [2:0] wr_chan;
  logic [7:0] wr_code;
  modport ctrl (output run, input wr_en, input wr_chan, input wr_code);
  modport seq (input run, output wr_en, output wr_chan, output wr_code);
endinterface : msas_seq_if

/* File: logic/msas_sequencer.sv */
// Round-robin conversion sequencer with remote diode averaging
`timescale 1ns/1ps
module msas_sequencer #(
  parameter int unsigned CONV_CYCLES = msas_pkg::CONV_CYC,
  parameter int unsigned DIODE_SUB_CYCLES = msas_pkg::DIODE_SUB_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] adc_code,
  output logic [2:0] adc_chan,
  msas_seq_if.seq sif
);
  import msas_pkg::*;

  logic [TIMER_W-1:0] timer_ff;
  logic [3:0] avg_cnt_ff;
  logic [11:0] acc_ff;
  logic [2:0] chan_ff;
  logic wr_en_ff;
  logic [7:0] wr_code_ff;
  logic [2:0] wr_chan_ff;
  logic is_diode;
  logic slot_end;
  logic [11:0] nxt_acc;

  assign is_diode = (chan_ff == CHAN_REMOTE_DIODE);
  assign slot_end = is_diode ? (timer_ff == TIMER_W'(DIODE_SUB_CYCLES - 1))
                             : (timer_ff == TIMER_W'(CONV_CYCLES - 1));
  assign nxt_acc = acc_ff + {4'h0, adc_code};
  assign adc_chan = chan_ff;
  assign sif.wr_en = wr_en_ff;
  assign sif.wr_code = wr_code_ff;
  assign sif.wr_chan = wr_chan_ff;

  // ==========================================================
  // Slot timer and channel stepping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_ff <= '0;
      chan_ff <= CHAN_FIRST;
      avg_cnt_ff <= 4'h0;
      acc_ff <= 12'h000;
    end else if (ce) begin
      if (!sif.run) begin // R13
        timer_ff <= '0;
        chan_ff <= CHAN_FIRST;
        avg_cnt_ff <= 4'h0;
        acc_ff <= 12'h000;
      end else if (!slot_end) begin
        timer_ff <= timer_ff + 1'b1; // R10
      end else begin
        timer_ff <= '0;
        if (is_diode) begin
          acc_ff <= (avg_cnt_ff == 4'hf) ? 12'h000 : nxt_acc; // R11
          avg_cnt_ff <= avg_cnt_ff + 1'b1;
          if (avg_cnt_ff == 4'hf) begin
            chan_ff <= CHAN_FIRST; // R07
          end
        end else begin
          chan_ff <= chan_ff + 1'b1; // R07
        end
      end
    end
  end

  // ==========================================================
  // Result write toward the value registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_en_ff <= 1'b0;
      wr_code_ff <= 8'h00;
      wr_chan_ff <= CHAN_FIRST;
    end else if (ce) begin
      wr_en_ff <= 1'b0;
      if (sif.run && slot_end && (!is_diode || avg_cnt_ff == 4'hf)) begin
        wr_en_ff <= 1'b1;
        wr_chan_ff <= chan_ff; // R08
        wr_code_ff <= is_diode ? nxt_acc[11:4] : adc_code; // R11 R09
      end
    end
  end
endmodule : msas_sequencer

/* File: logic/msas_top.sv */
// Monitor bus slave: pointer-based register access and value registers
// Behaviour
// R01 - Pointer-only write selects register, stores nothing
// R02 - Read returns one byte from pointed register
// R03 - Pointer persists between transactions
// R04 - First written byte always loads pointer
// R05 - Address is 01011 plus two strap bits
// R06 - Send, receive and read byte supported
// R07 - Sequence covers eight channels round robin
// R08 - Result stored as 8-bit channel code
// R09 - Nominal supply reads three-quarter scale code
// R10 - One ordinary channel per fixed interval
// R11 - Remote diode averages sixteen, longer slot
// R12 - Open strap decodes to low bits 10
// R13 - Config bit 0 starts and stops sequencing
// R14 - Writes one or two bytes, reads one
// R15 - Acknowledge own address and written bytes only
`timescale 1ns/1ps
module msas_top #(
  parameter int unsigned CONV_CYCLES = msas_pkg::CONV_CYC,
  parameter int unsigned DIODE_SUB_CYCLES = msas_pkg::DIODE_SUB_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_level,
  input wire logic strap_open,
  input wire logic [7:0] adc_code,
  output logic [2:0] adc_chan
);
  import msas_pkg::*;

  msas_seq_if sif ();

  logic scl_ff;
  logic sda_ff;
  logic scl_q_ff;
  logic sda_q_ff;
  msas_state_type state_ff;
  logic [3:0] bit_cnt_ff;
  logic [1:0] byte_cnt_ff;
  logic [7:0] shift_ff;
  logic rw_ff;
  logic sda_oe_ff;
  logic sda_out_ff;
  logic [7:0] ptr_ff;
  logic [7:0] config_ff;
  logic [1:0] addr_low_ff;
  logic strap_done_ff;
  logic [7:0] value_mem [NUM_CHAN];
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic wr_done;
  logic [7:0] rd_data;

  // Register read decode
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] cfg,
                                          input logic [7:0] val);
    if (addr == CONFIG_ADDR) begin
      return cfg;
    end else if (addr[7:3] == VALUE_BASE[7:3]) begin
      return val;
    end
    return 8'h00;
  endfunction : reg_read

  assign start_cond = scl_ff && scl_q_ff && sda_q_ff && !sda_ff;
  assign stop_cond = scl_ff && scl_q_ff && !sda_q_ff && sda_ff;
  assign scl_rise = scl_ff && !scl_q_ff;
  assign scl_fall = !scl_ff && scl_q_ff;
  assign wr_done = (state_ff == ST_WRITE) && scl_fall && (bit_cnt_ff == 4'h8);
  assign rd_data = reg_read(ptr_ff, config_ff, value_mem[ptr_ff[2:0]]); // R02
  assign sif.run = config_ff[CFG_START_BIT];
  assign sda_oe = sda_oe_ff;
  assign sda_out = sda_out_ff;

  // ==========================================================
  // Bus line sampling and edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else if (ce) begin
      scl_ff <= scl_in;
      sda_ff <= sda_in;
      scl_q_ff <= scl_ff;
      sda_q_ff <= sda_ff;
    end
  end

  // ==========================================================
  // Strap capture at first bus activity
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_low_ff <= ADDR_LOW_OPEN;
      strap_done_ff <= 1'b0;
    end else if (ce && start_cond && !strap_done_ff) begin
      strap_done_ff <= 1'b1;
      if (strap_open) begin
        addr_low_ff <= ADDR_LOW_OPEN; // R12
      end else begin
        addr_low_ff <= strap_level ? ADDR_LOW_VCC : ADDR_LOW_GND; // R05
      end
    end
  end

  // ==========================================================
  // Bus slave state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      byte_cnt_ff <= 2'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      sda_out_ff <= 1'b0; // Open drain: only ever pulls low
    end else if (ce) begin
      if (start_cond) begin
        state_ff <= ST_ADDR;
        bit_cnt_ff <= 4'h0;
        byte_cnt_ff <= 2'h0;
        sda_oe_ff <= 1'b0;
      end else if (stop_cond) begin
        state_ff <= ST_IDLE;
        sda_oe_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], sda_ff};
              bit_cnt_ff <= bit_cnt_ff + 1'b1;
            end else if (scl_fall && bit_cnt_ff == 4'h8) begin
              if (state_ff == ST_WRITE) begin
                sda_oe_ff <= 1'b1; // R15
                state_ff <= ST_ACK;
                if (byte_cnt_ff != 2'h3) begin
                  byte_cnt_ff <= byte_cnt_ff + 1'b1;
                end
              end else if (shift_ff[7:1] == {ADDR_UPPER, addr_low_ff}) begin // R05
                sda_oe_ff <= 1'b1; // R15
                rw_ff <= shift_ff[0];
                state_ff <= ST_ACK;
              end else begin
                state_ff <= ST_IGNORE; // R15
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_ff <= 4'h0;
              if (rw_ff) begin
                shift_ff <= rd_data; // R02 R03
                sda_oe_ff <= !rd_data[7];
                state_ff <= ST_READ;
              end else begin
                sda_oe_ff <= 1'b0;
                state_ff <= ST_WRITE;
              end
            end
          end
          ST_READ: begin
            if (scl_rise) begin
              bit_cnt_ff <= bit_cnt_ff + 1'b1;
            end else if (scl_fall) begin
              if (bit_cnt_ff == 4'h8) begin
                sda_oe_ff <= 1'b0;
                state_ff <= ST_RACK;
              end else begin
                sda_oe_ff <= !shift_ff[6];
                shift_ff <= {shift_ff[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              state_ff <= ST_IGNORE; // R14
            end
          end
          ST_IDLE, ST_IGNORE: begin
            sda_oe_ff <= 1'b0;
          end
          default: begin
            state_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Pointer and configuration writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_ff <= PTR_RESET;
      config_ff <= CONFIG_RESET;
    end else if (ce && wr_done) begin
      if (byte_cnt_ff == 2'h0) begin
        ptr_ff <= shift_ff; // R01 R04 R06
      end else if (byte_cnt_ff == 2'h1 && ptr_ff == CONFIG_ADDR) begin
        config_ff <= shift_ff; // R13 R14
      end
    end
  end

  // ==========================================================
  // Value registers filled by the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        value_mem[i] <= 8'h00;
      end
    end else if (ce && sif.wr_en) begin
      value_mem[sif.wr_chan] <= sif.wr_code; // R08
    end
  end

  msas_sequencer #(
    .CONV_CYCLES(CONV_CYCLES),
    .DIODE_SUB_CYCLES(DIODE_SUB_CYCLES)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .adc_code(adc_code),
    .adc_chan(adc_chan),
    .sif(sif.seq)
  );
endmodule : msas_top

/* File: tb/msas_monitor.sv */
// Checker: bus drive timing and conversion slot lengths
`timescale 1ns/1ps
module msas_monitor #(
  parameter int unsigned CONV_CYCLES = msas_pkg::CONV_CYC,
  parameter int unsigned DIODE_SUB_CYCLES = msas_pkg::DIODE_SUB_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [2:0] adc_chan
);
  logic [2:0] last_ff;
  logic [31:0] cnt_ff;
  // Enabled cycles spent on the shown channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_ff <= 3'h0;
      cnt_ff <= 32'h0;
    end else begin
      last_ff <= adc_chan;
      cnt_ff <= (adc_chan != last_ff) ? {31'h0, ce} : cnt_ff + {31'h0, ce};
    end
  end
  // ========================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_drive_zero: assert property (sda_out == 1'b0)
    else $error("sda_out high");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe moved with scl high");
  chk_oe_release: assert property ($rose(sda_oe) |-> ##[1:400] !sda_oe)
    else $error("sda held too long");
  chk_start_free: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> !sda_oe)
    else $error("driving at start");
  chk_chan_order: assert property ($changed(adc_chan) |-> adc_chan == $past(adc_chan) + 3'h1
    || adc_chan == 3'h0)
    else $error("channel order");
  chk_slot_len: assert property (adc_chan != last_ff && last_ff != 3'h0 && adc_chan != 3'h0
    |-> cnt_ff == CONV_CYCLES)
    else $error("slot length");
  chk_diode_len: assert property (adc_chan != last_ff && last_ff == 3'h7
    |-> cnt_ff <= 16 * DIODE_SUB_CYCLES)
    else $error("diode slot length");
  chk_freeze_hold: assert property (!ce |=> $stable(adc_chan) && $stable(sda_oe))
    else $error("moved with ce low");
endmodule : msas_monitor
bind msas_top msas_monitor #(.CONV_CYCLES(CONV_CYCLES), .DIODE_SUB_CYCLES(DIODE_SUB_CYCLES)) u_mon (
  .clk(clk), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .adc_chan(adc_chan));

/* File: tb/msas_master.sv */
// SMBus master model
`timescale 1ns/1ps
module msas_master (
  input wire logic clk,
  input wire logic sda_level,
  output logic scl,
  output logic sda_low
);
  // ========================
  // Idle bus, then bit tasks stepped on falling edges
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda_level;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask : bit_io
  task automatic start();
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b1;
    tick(8);
    scl = 1'b0;
    tick(4);
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b0;
    tick(8);
  endtask : stop
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : put_byte
  task automatic get_byte(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(1'b1, r);
  endtask : get_byte
endmodule : msas_master

/* File: tb/msas_top_test.sv */
// Testbench: strap decode, pointer access, sequencing
`timescale 1ns/1ps
module msas_top_test;
  import msas_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic strap_level; // Set at the top of each strap pass
  logic strap_open;
  logic [7:0] adc_code = 8'h00;
  logic [5:0] dcnt = 6'h0;
  logic [6:0] dev;
  logic scl, m_low, sda_oe, sda_out;
  logic [2:0] adc_chan;
  int miscompares = 0;
  int checks = 0;
  wire logic sda = !(m_low || (sda_oe && !sda_out));
  // ========================
  // Clock, master and block
  always #20 clk = ~clk;
  msas_master m (.clk(clk), .sda_level(sda), .scl(scl), .sda_low(m_low));
  msas_top #(.CONV_CYCLES(8), .DIODE_SUB_CYCLES(4)) uut (.clk(clk), .rst(rst), .ce(ce),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .strap_level(strap_level),
    .strap_open(strap_open), .adc_code(adc_code), .adc_chan(adc_chan));
  // Diode ramp: only a true average gives 8'h67
  function automatic logic [7:0] code(input logic [2:0] c, input logic [5:0] n);
    if (c == 3'h7) return 8'h60 + {4'h0, n[5:2]};
    if (c == 3'h5) return 8'hc0;
    return 8'h10 + {5'h0, c};
  endfunction : code
  // Converter stand-in
  always @(negedge clk) begin
    dcnt <= (adc_chan == 3'h7) ? dcnt + 6'h1 : 6'h0;
    adc_code <= code(adc_chan, dcnt);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // ========================
  // Bus transfers
  task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic [7:0] e, input int n);
    logic a;
    m.start();
    m.put_byte({dev, 1'b0}, a);
    check({7'h0, a}, 8'h01);
    m.put_byte(p, a);
    if (n > 0) m.put_byte(d, a);
    if (n > 1) m.put_byte(e, a);
    check({7'h0, a}, 8'h01);
    m.stop();
  endtask : wr
  task automatic rd(input logic [7:0] exp);
    logic a;
    logic [7:0] v;
    m.start();
    m.put_byte({dev, 1'b1}, a);
    m.get_byte(v);
    m.stop();
    check({7'h0, a}, 8'h01);
    check(v, exp);
  endtask : rd
  task automatic rdb(input logic [7:0] p, input logic [7:0] exp);
    logic a;
    m.start();
    m.put_byte({dev, 1'b0}, a);
    m.put_byte(p, a);
    rd(exp);
  endtask : rdb
  // ========================
  // Scenarios
  task automatic t_strap();
    logic a;
    logic [1:0] low;
    for (int s = 0; s < 3; s++) begin
      strap_open = (s == 0);
      strap_level = (s == 2);
      low = (s == 0) ? 2'h2 : {1'b0, s == 2};
      rst = 1'b1;
      m.tick(3);
      rst = 1'b0;
      m.start();
      m.put_byte({5'h0b, ~low, 1'b0}, a);
      m.stop();
      check({7'h0, a}, 8'h00);
      dev = {5'h0b, low};
      rd(8'h00);
    end
  endtask : t_strap
  task automatic t_run();
    wr(8'h40, 8'h01, 8'h00, 1);
    m.tick(300);
    for (int c = 0; c < 8; c++) rdb(8'h20 + c[7:0], code(c[2:0], 6'h1c));
  endtask : t_run
  task automatic t_ptr();
    wr(8'h40, 8'h00, 8'h00, 0);
    rd(8'h01);
    wr(8'h25, 8'h00, 8'h00, 0);
    rd(8'hc0);
  endtask : t_ptr
  task automatic t_stop();
    for (int i = 0; i < 300 && adc_chan !== 3'h1; i++) m.tick(1);
    ce = 1'b0;
    m.tick(20);
    check({5'h0, adc_chan}, 8'h01);
    ce = 1'b1;
    wr(8'h40, 8'h00, 8'h01, 2);
    rdb(8'h40, 8'h00);
    check({5'h0, adc_chan}, 8'h00);
  endtask : t_stop
  // Main sequence
  initial begin
    t_strap();
    t_run();
    t_ptr();
    t_stop();
    print_verdict();
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule : msas_top_test
